// File: verilog/dpf_pin_mux.sv
/*
 * dpf_pin_mux: function multiplexer for two general purpose pins.
 * Assumes status inputs come from same-clock logic, pins from outside.
 * The function setting is written through the documented register port.
 */
`timescale 1ns/1ns
// Behaviour
// R1 - each pin independently input or output
// R2 - output level equals status bit level
// R3 - invert bit inverts both output pins
// R4 - pin input overrides internal control bit
// R5 - manual pin select beats register selection
// R6 - other side avoids conflicting duplicate inputs
// R7 - upper nibble pin1, lower nibble pin0
// R8 - 0001 forces holdover on high
// R9 - 0010 forces mid control voltage
// R10 - low 0111 both pins select reference
// R11 - 1000 drives first loop lock
// R12 - 1001 drives second loop lock
// R13 - 1010 high when both loops locked
// R14 - 1011 low on enabled input loss
// R15 - 1100 low while in holdover
// R16 - 1101 drives interrupt level
// R17 - low 1111 both pins show reference
// R18 - pins sampled at reset release
// R19 - startup default 1010 upper, 1011 lower
// R20 - enables mask sticky bits for interrupt
// R21 - interrupt holds until sources cleared
// R22 - reserved codes act as unused inputs
// R23 - input pins pass two-flop synchroniser
module dpf_pin_mux
  import dpf_pkg::*;
#(
  parameter int unsigned NREF = dpf_pkg::DPF_NUM_REFS,
  parameter int unsigned NSTAT = dpf_pkg::DPF_NUM_STATUS
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [1:0] pin_in,
  output logic [1:0] pin_out,
  output logic [1:0] pin_oe,
  input wire logic func_wr,
  input wire logic [7:0] func_wdata,
  output logic [7:0] pin_function_select,
  output logic [7:0] strap_levels,
  input wire logic pin_output_invert,
  input wire logic force_mid_voltage_ctl,
  input wire logic force_holdover_ctl,
  input wire logic [1:0] reference_select_mode_bits,
  input wire logic [1:0] reg_ref_sel,
  input wire logic [NREF-1:0] reference_input_disable,
  input wire logic [NREF-1:0] signal_loss_alarm,
  input wire logic loop0_locked,
  input wire logic loop1_locked,
  input wire logic in_holdover,
  input wire logic [1:0] active_ref_idx,
  input wire logic [NSTAT-1:0] sticky_status_bits,
  input wire logic [NSTAT-1:0] irq_enable_bits,
  output logic force_holdover,
  output logic force_mid_voltage,
  output logic manual_ref_mode,
  output logic [1:0] ref_sel
);

  import dpf_pkg::*;

  // the reference index is two pins wide, so only four inputs fit
  if (NREF != 4)
  begin : g_bad_nref
    $error("dpf_pin_mux: NREF must be 4 for a 2-bit reference index");
  end
  if (NSTAT == 0)
  begin : g_bad_nstat
    $error("dpf_pin_mux: NSTAT must be at least 1");
  end

  logic [1:0] pin_sync;
  logic irq_level;
  logic [7:0] func_d;
  logic [7:0] func_q;
  logic [1:0] boot_d;
  logic [1:0] boot_q;
  logic [7:0] strap_d;
  logic [7:0] strap_q;
  logic [3:0] code [2];
  logic [1:0] is_out;
  logic [1:0] raw_out;
  logic manual_sel;
  logic status_sel;
  logic [1:0] fh_hit;
  logic [1:0] fm_hit;
  logic alarm_ok;

  dpf_sync2 #(
    .WIDTH(2)
  ) u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .async_in(pin_in),
    .sync_out(pin_sync) // [R23]
  );

  dpf_irq #(
    .NSTAT(NSTAT)
  ) u_irq (
    .clk(clk),
    .rst_b(rst_b),
    .sticky_status_bits(sticky_status_bits),
    .irq_enable_bits(irq_enable_bits),
    .irq_level(irq_level)
  );

  // setting register and reset-release strap capture
  always_comb
  begin
    func_d = func_q;
    boot_d = boot_q;
    strap_d = strap_q;
    if (boot_q != 2'h3)
      boot_d = boot_q + 2'h1;
    // sync flops are cleared by reset; wait until they show the level
    // the board drove at the first edge, before any pin is driven
    if (boot_q == DPF_STRAP_AGE)
      strap_d = {6'h00, pin_sync}; // [R18]
    if (func_wr)
      func_d = func_wdata; // register port write replaces the setting
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      func_q <= DPF_FUNC_RESET; // [R19]
      boot_q <= 2'h0;
      strap_q <= 8'h00;
    end
    else
    begin
      func_q <= func_d;
      boot_q <= boot_d;
      strap_q <= strap_d;
    end
  end

  assign pin_function_select = func_q;
  assign strap_levels = strap_q;

  // per-pin code split [R7]
  assign code[1] = func_q[DPF_PIN1_CODE_MSB:DPF_PIN1_CODE_LSB];
  assign code[0] = func_q[DPF_PIN0_CODE_MSB:DPF_PIN0_CODE_LSB];

  assign manual_sel = (code[0] == DPF_CODE_MANUAL_SEL); // [R10]
  assign status_sel = (code[0] == DPF_CODE_SEL_STATUS); // [R17]

  // any enabled input losing signal pulls the alarm low
  assign alarm_ok = ~|(signal_loss_alarm & ~reference_input_disable); // [R14]

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_pin
      always_comb
      begin
        raw_out[gi] = 1'b0;
        is_out[gi] = 1'b0;
        fh_hit[gi] = 1'b0;
        fm_hit[gi] = 1'b0;
        if (manual_sel)
        begin
          is_out[gi] = 1'b0; // [R10]
        end
        else if (status_sel)
        begin
          is_out[gi] = 1'b1;
          raw_out[gi] = active_ref_idx[gi]; // [R17]
        end
        else
        begin
          // reserved codes fall through as unused inputs [R22]
          unique case (code[gi])
            DPF_CODE_FORCE_HOLD: fh_hit[gi] = 1'b1; // [R8]
            DPF_CODE_FORCE_MID: fm_hit[gi] = 1'b1; // [R9]
            DPF_CODE_LOCK0:
            begin
              is_out[gi] = 1'b1;
              raw_out[gi] = loop0_locked; // [R11] [R2]
            end
            DPF_CODE_LOCK1:
            begin
              is_out[gi] = 1'b1;
              raw_out[gi] = loop1_locked; // [R12]
            end
            DPF_CODE_LOCK_BOTH:
            begin
              is_out[gi] = 1'b1;
              raw_out[gi] = loop0_locked & loop1_locked; // [R13]
            end
            DPF_CODE_ALARM:
            begin
              is_out[gi] = 1'b1;
              raw_out[gi] = alarm_ok; // [R14]
            end
            DPF_CODE_HOLDOVER:
            begin
              is_out[gi] = 1'b1;
              raw_out[gi] = ~in_holdover; // [R15]
            end
            DPF_CODE_IRQ:
            begin
              is_out[gi] = 1'b1;
              raw_out[gi] = irq_level; // [R16]
            end
            default:
            begin
              is_out[gi] = 1'b0;
            end
          endcase
        end
      end
    end
  endgenerate

  // pin drivers: each pin steered by its own code unless pin0 holds 0111 or 1111 [R1]
  logic [1:0] out_d;
  logic [1:0] out_q;
  logic [1:0] oe_d;
  logic [1:0] oe_q;

  always_comb
  begin
    oe_d = is_out;
    out_d = is_out & (raw_out ^ {2{pin_output_invert}}); // [R3]
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      out_q <= 2'b00;
      oe_q <= 2'b00;
    end
    else
    begin
      out_q <= out_d;
      oe_q <= oe_d;
    end
  end

  assign pin_out = out_q;
  assign pin_oe = oe_q;

  // input functions replace their register controls; a pin mapped to
  // the same function twice ORs, since conflicting levels are undefined;
  // registered so a setting change cannot glitch the loop controls
  logic fh_d;
  logic fh_q;
  logic fm_d;
  logic fm_q;
  logic manual_d;
  logic manual_q;
  logic [1:0] ref_sel_d;
  logic [1:0] ref_sel_q;

  always_comb
  begin
    fh_d = force_holdover_ctl;
    fm_d = force_mid_voltage_ctl;
    manual_d = 1'b0;
    ref_sel_d = reg_ref_sel;
    if (|fh_hit)
    begin
      fh_d = |(fh_hit & pin_sync); // [R4] [R8] [R6]
      fm_d = 1'b0; // [R4]
    end
    if (|fm_hit)
      fm_d = |(fm_hit & pin_sync); // [R9] [R4]
    if (manual_sel)
    begin
      manual_d = 1'b1;
      ref_sel_d = pin_sync; // [R5] [R10]
    end
    else if (reference_select_mode_bits == 2'h0)
      ref_sel_d = reg_ref_sel;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      fh_q <= 1'b0;
      fm_q <= 1'b0;
      manual_q <= 1'b0;
      ref_sel_q <= 2'h0;
    end
    else
    begin
      fh_q <= fh_d;
      fm_q <= fm_d;
      manual_q <= manual_d;
      ref_sel_q <= ref_sel_d;
    end
  end

  assign force_holdover = fh_q;
  assign force_mid_voltage = fm_q;
  assign manual_ref_mode = manual_q;
  assign ref_sel = ref_sel_q;

endmodule : dpf_pin_mux

// File: include/dpf_pkg.sv
/*
 * dpf_pkg: constants for the dual pin function multiplexer.
 * Assumes a single 10 MHz clock domain and an active-low async reset.
 */
package dpf_pkg;

  localparam int unsigned DPF_NUM_REFS = 4;
  localparam int unsigned DPF_NUM_STATUS = 8;

  // function code field positions in the 8-bit setting
  localparam int unsigned DPF_PIN1_CODE_MSB = 7;
  localparam int unsigned DPF_PIN1_CODE_LSB = 4;
  localparam int unsigned DPF_PIN0_CODE_MSB = 3;
  localparam int unsigned DPF_PIN0_CODE_LSB = 0;

  localparam logic [3:0] DPF_CODE_FORCE_HOLD = 4'h1;
  localparam logic [3:0] DPF_CODE_FORCE_MID = 4'h2;
  localparam logic [3:0] DPF_CODE_MANUAL_SEL = 4'h7;
  localparam logic [3:0] DPF_CODE_LOCK0 = 4'h8;
  localparam logic [3:0] DPF_CODE_LOCK1 = 4'h9;
  localparam logic [3:0] DPF_CODE_LOCK_BOTH = 4'hA;
  localparam logic [3:0] DPF_CODE_ALARM = 4'hB;
  localparam logic [3:0] DPF_CODE_HOLDOVER = 4'hC;
  localparam logic [3:0] DPF_CODE_IRQ = 4'hD;
  localparam logic [3:0] DPF_CODE_SEL_STATUS = 4'hF;

  // default setting after startup: pin1 combined lock, pin0 alarm
  localparam logic [7:0] DPF_FUNC_RESET = 8'hAB;

  // edge count after reset release at which the synchroniser holds pins
  localparam logic [1:0] DPF_STRAP_AGE = 2'h2;

endpackage : dpf_pkg

// File: verilog/dpf_sync2.sv
/*
 * dpf_sync2: two-flop synchroniser for the pin input levels.
 * Assumes inputs are asynchronous to clk.
 */
`timescale 1ns/1ns
module dpf_sync2 #(
  parameter int unsigned WIDTH = 2
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule : dpf_sync2

// File: verilog/dpf_irq.sv
/*
 * dpf_irq: masked interrupt level from sticky status bits.
 * Assumes the sticky bits are kept by the status register block.
 */
`timescale 1ns/1ns
module dpf_irq #(
  parameter int unsigned NSTAT = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [NSTAT-1:0] sticky_status_bits,
  input wire logic [NSTAT-1:0] irq_enable_bits,
  output logic irq_level
);

  logic irq_d;
  logic irq_q;

  // pending until every enabled sticky source is cleared [R20] [R21]
  always_comb
  begin
    irq_d = |(sticky_status_bits & irq_enable_bits);
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      irq_q <= 1'b0;
    else
      irq_q <= irq_d;
  end

  assign irq_level = irq_q;

endmodule : dpf_irq

// File: bench/dpf_chk.sv
/* dpf_chk: port assertions for dpf_pin_mux.
   assumes one clock and the bind in tb_top. */
`timescale 1ns/1ns
module dpf_chk
  import dpf_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [1:0] pin_in,
  input wire logic [1:0] pin_out,
  input wire logic [1:0] pin_oe,
  input wire logic func_wr,
  input wire logic [7:0] func_wdata,
  input wire logic [7:0] pin_function_select,
  input wire logic pin_output_invert,
  input wire logic [1:0] active_ref_idx,
  input wire logic force_holdover,
  input wire logic manual_ref_mode,
  input wire logic [1:0] ref_sel
);
  logic [1:0] age_q;
  logic [3:0] lo;
  logic [3:0] hi;
  assign lo = pin_function_select[3:0];
  assign hi = pin_function_select[7:4];
  // sync flops need two edges out of reset before pins count
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      age_q <= 2'h0;
    else if (age_q != 2'h3)
      age_q <= age_q + 2'h1;
  end
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  a_reset_default: assert property ($rose(rst_b) |->
    pin_function_select == DPF_FUNC_RESET) else $error("no default");
  a_write_take: assert property (func_wr |=>
    pin_function_select == $past(func_wdata)) else $error("write lost");
  a_setting_hold: assert property (!func_wr |=>
    $stable(pin_function_select)) else $error("setting moved");
  a_sel_shown: assert property (|age_q && lo == 4'hF &&
    $stable(pin_function_select) |-> pin_oe == 2'h3 && pin_out ==
    ($past(active_ref_idx) ^ {2{$past(pin_output_invert)}}))
    else $error("index not shown");
  a_input_float: assert property (|age_q && lo inside {4'h1, 4'h2} &&
    $stable(pin_function_select) |-> !pin_oe[0]) else $error("pin driven");
  a_reserved_off: assert property (|age_q && hi == 4'hE &&
    !(lo inside {4'h7, 4'hF}) && $stable(pin_function_select) |->
    pin_oe[1] == 1'b0 && pin_out[1] == 1'b0) else $error("reserved");
  a_force_hold: assert property (age_q == 2'h3 && lo == 4'h1 &&
    hi != 4'h1 && $stable(pin_function_select) |->
    force_holdover == $past(pin_in[0], 3)) else $error("holdover pin");
  a_manual_sel: assert property (age_q == 2'h3 && lo == 4'h7 &&
    $stable(pin_function_select) |-> manual_ref_mode &&
    ref_sel == $past(pin_in, 3)) else $error("manual");
endmodule : dpf_chk

// File: bench/dpf_board.sv
/* dpf_board: board side of the two pins.
   assumes it backs off a pin the mux drives. */
`timescale 1ns/1ns
module dpf_board (
  input wire logic [1:0] pin_out,
  input wire logic [1:0] pin_oe,
  input wire logic [1:0] drv_lvl,
  output logic [1:0] pin_in
);
  // no contention: board drives only released pins
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & drv_lvl);
endmodule : dpf_board

// File: bench/tb_top.sv
/* tb_top: self-checking bench for dpf_pin_mux.
   assumes dpf_board and dpf_chk compile first. */
`timescale 1ns/1ns
module tb_top;
  import dpf_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic wr = 1'b0;
  logic [7:0] wd = 8'h00;
  logic [35:0] r = '0;
  // board straps a nonzero level through reset so the capture shows
  logic [1:0] dv = 2'h2;
  logic [31:0] seed = 32'hFA4E0235;
  logic [1:0] pi, po, oe, rs;
  logic [7:0] fs, sl, s;
  logic fh, fm, mm;
  int err_total = 0;
  int comparisons = 0;
  always #50 clk = ~clk;
  dpf_board board_u (.pin_out(po), .pin_oe(oe), .drv_lvl(dv), .pin_in(pi));
  dpf_pin_mux dut_u (.clk(clk), .rst_b(rst_b), .pin_in(pi), .pin_out(po),
    .pin_oe(oe), .func_wr(wr), .func_wdata(wd), .pin_function_select(fs),
    .strap_levels(sl), .pin_output_invert(r[0]),
    .force_mid_voltage_ctl(r[1]), .force_holdover_ctl(r[2]),
    .reference_select_mode_bits(r[4:3]), .reg_ref_sel(r[6:5]),
    .reference_input_disable(r[10:7]), .signal_loss_alarm(r[14:11]),
    .loop0_locked(r[15]), .loop1_locked(r[16]), .in_holdover(r[17]),
    .active_ref_idx(r[19:18]), .sticky_status_bits(r[27:20]),
    .irq_enable_bits(r[35:28]), .force_holdover(fh),
    .force_mid_voltage(fm), .manual_ref_mode(mm), .ref_sel(rs));
  // {oe, level} of one pin for a code
  function automatic logic [1:0] pin_exp(input logic [3:0] c);
    logic [5:0] v;
    v = {|(r[27:20] & r[35:28]), ~r[17], ~|(r[14:11] & ~r[10:7]),
      r[15] & r[16], r[16], r[15]};
    if (c < 4'h8 || c > 4'hD)
      return 2'h0;
    return {1'b1, v[c - 4'h8] ^ r[0]};
  endfunction : pin_exp
  function automatic logic [7:0] pins_exp(input logic [7:0] f);
    logic [1:0] a;
    logic [1:0] b;
    a = pin_exp(f[7:4]);
    b = pin_exp(f[3:0]);
    if (f[3:0] == 4'h7)
      return 8'h00;
    if (f[3:0] == 4'hF)
      return {6'h03, r[19:18] ^ {2{r[0]}}};
    return {4'h0, a[1], b[1], a[0], b[0]};
  endfunction : pins_exp
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic report_and_stop();
    if (err_total == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr
  task automatic draw();
    seed = lfsr(seed);
    r[31:0] = seed;
    seed = lfsr(seed);
    r[35:32] = seed[3:0];
  endtask : draw
  // leaves the strobe high so writes may run back to back
  task automatic put(input logic [7:0] d);
    wd = d;
    wr = 1'b1;
    @(negedge clk);
  endtask : put
  // pins need two sync edges plus the registered control outputs
  task automatic settle();
    wr = 1'b0;
    repeat (5) @(negedge clk);
    chk(fs, wd);
    chk({4'h0, oe, po}, pins_exp(wd));
  endtask : settle
  // strap lands three edges after release, from the released pins
  task automatic boot_chk();
    repeat (4) @(negedge clk);
    chk(fs, DPF_FUNC_RESET);
    chk(sl, {6'h00, dv});
    chk({4'h0, oe, po}, pins_exp(DPF_FUNC_RESET));
  endtask : boot_chk
  initial
  begin
    repeat (8) @(negedge clk);
    rst_b = 1'b1;
    boot_chk();
    put(8'h8F);
    put(8'h5C);
    settle();
    for (int k = 0; k < 60; k++)
    begin
      draw();
      put(k < 2 ? 8'hE0 : seed[11:4]);
      settle();
    end
    for (int k = 0; k < 24; k++)
    begin
      draw();
      dv = seed[13:12];
      s = k % 3 == 0 ? 8'h81 : k % 3 == 1 ? 8'h2C : 8'h57;
      put(s);
      settle();
      chk({5'h0, fh, fm, mm},
        {5'h0, s == 8'h81 ? dv[0] : r[2],
        s == 8'h2C ? dv[1] : r[1] & s != 8'h81, s == 8'h57});
      if (s == 8'h57)
        chk({6'h00, rs}, {6'h00, dv});
      else
        chk({6'h00, rs}, {6'h00, r[6:5]});
    end
    dv = 2'h1;
    rst_b = 1'b0;
    @(negedge clk);
    chk(fs, DPF_FUNC_RESET);
    chk({4'h0, oe, po}, 8'h00);
    @(negedge clk);
    rst_b = 1'b1;
    boot_chk();
    report_and_stop();
  end
  initial
  begin
    #(3000 * 100);
    err_total++;
    report_and_stop();
  end
endmodule : tb_top

bind dpf_pin_mux dpf_chk chk_u (.*);
